// ==== hdl/ahp_defines.svh ====
/*
  Offsets, field positions, reset values and timing counts of the homing block.
  Assumes a 100 MHz clock and a 32-bit AXI4-Lite register bus.
*/
`ifndef AHP_DEFINES_SVH
`define AHP_DEFINES_SVH
////////////////////////////////////////////////////////////////////////////////
// Timing
`define AHP_CLK_NS         10
`define AHP_MS_NS          1000000
`define AHP_MS_CYCLES      (`AHP_MS_NS / `AHP_CLK_NS)
`define AHP_PERIOD_STEP_MS 3'h1
`define AHP_PERIOD_CONT_MS 3'h5
////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define AHP_OFF_CTRL   8'h00
`define AHP_OFF_ORIGIN 8'h04
`define AHP_OFF_COMP   8'h08
`define AHP_OFF_HIGH   8'h0c
`define AHP_OFF_LOW    8'h10
`define AHP_OFF_ACC    8'h14
`define AHP_OFF_DEC    8'h18
`define AHP_OFF_BASIC  8'h1c
`define AHP_OFF_DWELL  8'h20
`define AHP_OFF_WAIT   8'h24
`define AHP_OFF_OVR    8'h28
`define AHP_OFF_SSP    8'h2c
`define AHP_OFF_SSPTGT 8'h30
`define AHP_OFF_POS    8'h34
`define AHP_OFF_STATUS 8'h38
`define AHP_OFF_CMD    8'h3c
////////////////////////////////////////////////////////////////////////////////
// Control word fields
`define AHP_CTRL_METHOD 2:0
`define AHP_CTRL_DIR    3
`define AHP_CTRL_CONT   4
`define AHP_CTRL_LEVEL  5
`define AHP_CTRL_OVR    6
`define AHP_CTRL_EMGORG 7
`define AHP_CTRL_SSPABS 8
`define AHP_CTRL_EMGEN  9
`define AHP_CTRL_POL    14:10
// Command word bits
`define AHP_CMD_HOME 0
`define AHP_CMD_CONT 1
`define AHP_CMD_SSP  2
`define AHP_CMD_CLR  3
// Values
`define AHP_ERR_CONT  8'ha0
`define AHP_OVR_RESET 32'h0000_2710
`define AHP_OVR_SCALE 48'h0000_0000_2710
`define AHP_RESP_OK   2'h0
`define AHP_RESP_ERR  2'h2
`endif

// ==== hdl/ahp_pkg.sv ====
/*
  Types of the homing block: sequencer states and homing methods.
  Assumes nothing of its surroundings.
*/
package ahp_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    AHP_IDLE  = 3'b000,
    AHP_FAST  = 3'b001,
    AHP_SLOW  = 3'b010,
    AHP_COMP  = 3'b011,
    AHP_DWELL = 3'b100,
    AHP_WAIT  = 3'b101
  } ahp_state_t;
  // Homing method codes
  typedef enum logic [2:0] {
    AHP_M_AREA_OFF   = 3'b000,
    AHP_M_AREA_ON    = 3'b001,
    AHP_M_LIMIT_MARK = 3'b010,
    AHP_M_AREA       = 3'b011,
    AHP_M_HIGH       = 3'b100,
    AHP_M_LIMIT      = 3'b101,
    AHP_M_MARK       = 3'b110
  } ahp_method_t;
endpackage

// ==== hdl/ahp_tick_gen.sv ====
/*
  Millisecond tick and profile tick divider.
  Assumes one free-running clock; the enables are one-cycle pulses.
*/
`timescale 1ns/1ps
`include "ahp_defines.svh"
module ahp_tick_gen #(
  parameter int MS_CYCLES = `AHP_MS_CYCLES  // Clock cycles per millisecond
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic contEnable,  // Continuous operation enabled
  output logic      msTick,      // One pulse each millisecond
  output logic      profTick     // One pulse each profile period
);
  logic [31:0] cycleCount;  // Cycles within the millisecond
  logic [2:0]  msCount;     // Milliseconds within the period
  wire  [2:0]  periodMs = contEnable ? `AHP_PERIOD_CONT_MS : `AHP_PERIOD_STEP_MS;
  wire         msEnd    = (cycleCount == 32'(MS_CYCLES - 1));
  wire         periodEnd = (msCount >= periodMs - 3'h1);

  ////////////////////////////////////////////////////////////////////////////
  // Divider; period switches at the next millisecond boundary
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cycleCount <= 32'h0;
      msCount    <= 3'h0;
      msTick     <= 1'b0;
      profTick   <= 1'b0;
    end else begin
      cycleCount <= msEnd ? 32'h0 : cycleCount + 32'h1;
      msTick     <= msEnd;
      profTick   <= msEnd && periodEnd;
      if (msEnd) begin
        msCount <= periodEnd ? 3'h0 : msCount + 3'h1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_profile_one_ms: assert property (!contEnable && !$past(contEnable, 2)
    && msCount == 3'h0 |-> profTick == msTick)
    else $error("profile tick not on every millisecond");
endmodule

// ==== hdl/ahp_pulse_gen.sv ====
/*
  Rate accumulator turning a speed in pulses per second into step pulses.
  Assumes the speed is below half the clock rate.
*/
`timescale 1ns/1ps
`include "ahp_defines.svh"
module ahp_pulse_gen #(
  parameter int CLK_HZ = `AHP_MS_CYCLES * 1000  // Clock rate in hertz
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        runEnable,  // Low halts at once
  input  wire logic [31:0] speed,      // Pulses per second
  output logic             stepPulse   // One-cycle step
);
  logic [31:0] phase;  // Fraction of a pulse accumulated
  wire  [32:0] sum  = {1'b0, phase} + {1'b0, speed};
  wire         wrap = (sum >= 33'(CLK_HZ));

  ////////////////////////////////////////////////////////////////////////////
  // Halt clears the phase too, so no stale pulse leaks out afterwards
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase     <= 32'h0;
      stepPulse <= 1'b0;
    end else if (!runEnable) begin
      phase     <= 32'h0;
      stepPulse <= 1'b0;
    end else begin
      phase     <= wrap ? 32'(sum - 33'(CLK_HZ)) : sum[31:0];
      stepPulse <= wrap;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_halt_no_step: assert property (!runEnable |=> !stepPulse)
    else $error("step pulse after halt");
endmodule

// ==== hdl/ahp_axis_homing.sv ====
/*
  Per-axis homing sequencer with sensor polarity, pulse output level,
  override, speed/position switch target and AXI4-Lite registers.
  Assumes sensor inputs are synchronous to clk and the speed order is kept.
*/
`timescale 1ns/1ps
`include "ahp_defines.svh"
module ahp_axis_homing
  import ahp_pkg::*;
#(
  parameter int MS_CYCLES = `AHP_MS_CYCLES  // Clock cycles per millisecond
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        hiLimitIn,        // Raw high limit
  input  wire logic        loLimitIn,        // Raw low limit
  input  wire logic        areaSensorIn,     // Raw home-area sensor
  input  wire logic        homeMarkIn,       // Raw home mark
  input  wire logic        emergency_halt,   // Raw external stop
  output logic             pulseOut,         // Pulse train to the drive
  output logic             dirOut,           // High while moving in reverse
  output logic             origin_state      // Origin established
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] ctrl, originAddr, compAmount, highSpeed, lowSpeed;
  logic [31:0] accTime, decTime, basicTime, overrideVal, sspDist, sspTarget;
  logic [31:0] position;                 // Present position in pulses
  logic [15:0] dwellTime, waitTime;      // Millisecond counts
  logic [7:0]  errorCode;                // Last refused command
  logic        contActive;               // Continuous mode accepted
  ahp_state_t  state, next_state;        // Sequencer state
  logic        runDir;                   // Current travel, 1 is reverse
  logic [31:0] curSpeed;                 // Ramped speed
  logic [39:0] rampBudget;               // Slope accumulator
  logic [31:0] compLeft;                 // Compensation pulses left
  logic [15:0] msCount;                  // Milliseconds in this state
  logic        dogOffSeen;               // Area left during low speed
  logic        homePrev;                 // Home mark delayed
  logic        msTick, profTick, stepPulse;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = wstrb[i] ? wdata[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; both address and data must be present, one write at a time
  wire wrFire = awvalid && wvalid && !bvalid;
  wire rdFire = arvalid && !rvalid;
  assign awready = wrFire;
  assign wready  = wrFire;
  assign arready = rdFire;
  wire wrCmd  = wrFire && awaddr == `AHP_OFF_CMD && wstrb[0];
  wire startCmd = wrCmd && wdata[`AHP_CMD_HOME];
  wire contCmd  = wrCmd && wdata[`AHP_CMD_CONT];
  wire sspCmd   = wrCmd && wdata[`AHP_CMD_SSP];
  wire clrCmd   = wrCmd && wdata[`AHP_CMD_CLR];
  wire [31:0] status = {15'h0, dirOut, errorCode, 1'b0, contActive,
                        state != AHP_IDLE, origin_state, 1'b0, state};
  wire        rdOk = araddr[1:0] == 2'h0 && araddr <= `AHP_OFF_CMD;
  wire [31:0] rdMux =
    araddr == `AHP_OFF_CTRL   ? ctrl :
    araddr == `AHP_OFF_ORIGIN ? originAddr :
    araddr == `AHP_OFF_COMP   ? compAmount :
    araddr == `AHP_OFF_HIGH   ? highSpeed :
    araddr == `AHP_OFF_LOW    ? lowSpeed :
    araddr == `AHP_OFF_ACC    ? accTime :
    araddr == `AHP_OFF_DEC    ? decTime :
    araddr == `AHP_OFF_BASIC  ? basicTime :
    araddr == `AHP_OFF_DWELL  ? {16'h0, dwellTime} :
    araddr == `AHP_OFF_WAIT   ? {16'h0, waitTime} :
    araddr == `AHP_OFF_OVR    ? overrideVal :
    araddr == `AHP_OFF_SSP    ? sspDist :
    araddr == `AHP_OFF_SSPTGT ? sspTarget :
    araddr == `AHP_OFF_POS    ? position :
    araddr == `AHP_OFF_STATUS ? status : 32'h0;
  wire wrOk = awaddr[1:0] == 2'h0 && awaddr <= `AHP_OFF_CMD;

  ////////////////////////////////////////////////////////////////////////////
  // Polarity: a set bit means normally closed, active when the line is off
  wire [4:0] pol    = ctrl[`AHP_CTRL_POL];
  wire hiAct  = hiLimitIn ^ pol[0];
  wire loAct  = loLimitIn ^ pol[1];
  wire dogAct = areaSensorIn ^ pol[2];
  wire homeAct = homeMarkIn ^ pol[3];
  wire emgAct = emergency_halt ^ pol[4];
  wire homeEdge = homeAct && !homePrev;
  wire emgHit = ctrl[`AHP_CTRL_EMGEN] && emgAct;

  ////////////////////////////////////////////////////////////////////////////
  // Method conditions
  ahp_method_t method;
  assign method = ahp_method_t'(ctrl[`AHP_CTRL_METHOD]);
  wire methodOk = ctrl[`AHP_CTRL_METHOD] != 3'h7;
  wire baseDir  = ctrl[`AHP_CTRL_DIR];
  wire limAhead = runDir ? loAct : hiAct;
  wire isM0 = method == AHP_M_AREA_OFF;
  wire isM2 = method == AHP_M_LIMIT_MARK;
  wire originFast = ((method == AHP_M_AREA || method == AHP_M_HIGH) && dogAct)
                    || (method == AHP_M_LIMIT && limAhead);
  wire slowGo = ((isM0 || method == AHP_M_AREA_ON) && dogAct) || (isM2 && limAhead)
                || method == AHP_M_MARK;
  wire homeOk = homeEdge && (!isM0 || dogOffSeen);
  wire originHit = (state == AHP_FAST && originFast) || (state == AHP_SLOW && homeOk);
  wire timeUp = msCount >= (state == AHP_DWELL ? dwellTime : waitTime);
  wire doneNow = state == AHP_DWELL && timeUp && !emgHit;
  wire moving = state == AHP_FAST || state == AHP_SLOW || state == AHP_COMP;
  wire compEnd = state == AHP_COMP && (compLeft == 32'h0 ||
                 (compLeft == 32'h1 && stepPulse));
  wire runEn = moving && !originHit && !emgHit && !compEnd;

  ////////////////////////////////////////////////////////////////////////////
  // Speeds: override scales high speed, or replaces it when the override bit is set; ramp slope follows the effective high speed
  wire [47:0] ovrProd = highSpeed * {16'h0, overrideVal[15:0]};
  wire [47:0] ovrPct  = ovrProd / `AHP_OVR_SCALE;
  wire [31:0] effHigh = ctrl[`AHP_CTRL_OVR] ? overrideVal : ovrPct[31:0];
  wire [31:0] tgtSpeed = state == AHP_FAST ? effHigh : lowSpeed;
  wire        rampUp  = curSpeed < tgtSpeed;
  wire [31:0] effTime = rampUp ? (accTime != 32'h0 ? accTime : basicTime)
                               : (decTime != 32'h0 ? decTime : basicTime);
  wire [2:0]  periodMs = ctrl[`AHP_CTRL_CONT] ? `AHP_PERIOD_CONT_MS : `AHP_PERIOD_STEP_MS;
  wire [39:0] slope = 40'(effHigh) * 40'(periodMs);

  ahp_tick_gen #(.MS_CYCLES(MS_CYCLES)) uTick (
    .clk        (clk),
    .reset      (reset),
    .contEnable (ctrl[`AHP_CTRL_CONT]),
    .msTick     (msTick),
    .profTick   (profTick)
  );

  ahp_pulse_gen #(.CLK_HZ(MS_CYCLES * 1000)) uPulse (
    .clk       (clk),
    .reset     (reset),
    .runEnable (runEn),
    .speed     (curSpeed),
    .stepPulse (stepPulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state; emergency overrides every step
  always_comb begin
    next_state = state;
    if (emgHit) begin
      next_state = AHP_IDLE;
    end else begin
      case (state)
        AHP_IDLE:  if (startCmd && methodOk) next_state = AHP_FAST;
        AHP_FAST: begin
          if (originFast) next_state = AHP_COMP;
          else if (slowGo) next_state = AHP_SLOW;
          else if (limAhead) next_state = AHP_WAIT;
        end
        AHP_SLOW: begin
          if (homeOk) next_state = AHP_COMP;
          else if (limAhead) next_state = AHP_WAIT;
        end
        AHP_COMP:  if (compEnd) next_state = AHP_DWELL;
        AHP_DWELL: if (timeUp) next_state = AHP_IDLE;
        AHP_WAIT:  if (timeUp) next_state = AHP_FAST;
        default:   next_state = AHP_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake and software-written registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bvalid <= 1'b0;
      bresp  <= `AHP_RESP_OK;
      rvalid <= 1'b0;
      rresp  <= `AHP_RESP_OK;
      rdata  <= 32'h0;
    end else begin
      if (wrFire) begin
        bvalid <= 1'b1;
        bresp  <= wrOk ? `AHP_RESP_OK : `AHP_RESP_ERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      if (rdFire) begin
        rvalid <= 1'b1;
        rdata  <= rdOk ? rdMux : 32'h0;
        rresp  <= rdOk ? `AHP_RESP_OK : `AHP_RESP_ERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Settings; taken at once, so change them only while idle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {ctrl, originAddr, compAmount, highSpeed, lowSpeed} <= '0;
      {accTime, decTime, basicTime, sspDist} <= '0;
      {dwellTime, waitTime} <= '0;
      overrideVal <= `AHP_OVR_RESET;
    end else if (wrFire) begin
      case (awaddr)
        `AHP_OFF_CTRL:   ctrl <= merge(ctrl);
        `AHP_OFF_ORIGIN: originAddr <= merge(originAddr);
        `AHP_OFF_COMP:   compAmount <= merge(compAmount);
        `AHP_OFF_HIGH:   highSpeed <= merge(highSpeed);
        `AHP_OFF_LOW:    lowSpeed <= merge(lowSpeed);
        `AHP_OFF_ACC:    accTime <= merge(accTime);
        `AHP_OFF_DEC:    decTime <= merge(decTime);
        `AHP_OFF_BASIC:  basicTime <= merge(basicTime);
        `AHP_OFF_DWELL:  dwellTime <= 16'(merge({16'h0, dwellTime}));
        `AHP_OFF_WAIT:   waitTime <= 16'(merge({16'h0, waitTime}));
        `AHP_OFF_OVR:    overrideVal <= merge(overrideVal);
        `AHP_OFF_SSP:    sspDist <= merge(sspDist);
        default:         ;  // Read-only, command or unmapped
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer, direction and flags
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= AHP_IDLE;
      runDir <= 1'b0;
      msCount <= 16'h0;
      dogOffSeen <= 1'b0;
      homePrev <= 1'b0;
      origin_state <= 1'b0;
      errorCode <= 8'h0;
      contActive <= 1'b0;
      compLeft <= 32'h0;
    end else begin
      state <= next_state;
      homePrev <= homeAct;
      msCount <= (next_state != state) ? 16'h0 :
                 (msTick && msCount != 16'hffff) ? msCount + 16'h1 : msCount;
      dogOffSeen <= state == AHP_SLOW && (dogOffSeen || !dogAct);
      if (next_state == AHP_FAST) runDir <= baseDir;
      else if (state == AHP_FAST && next_state == AHP_SLOW && isM2) runDir <= !runDir;
      if (originHit && !emgHit) begin
        compLeft <= compAmount[31] ? 32'(-compAmount) : compAmount;
        runDir <= baseDir ^ compAmount[31];
      end else if (state == AHP_COMP && stepPulse && compLeft != 32'h0) begin
        compLeft <= compLeft - 32'h1;
      end
      if (doneNow) origin_state <= 1'b1;
      else if (startCmd && state == AHP_IDLE) origin_state <= 1'b0;
      else if (emgHit && ctrl[`AHP_CTRL_EMGORG]) origin_state <= 1'b0;
      if (contCmd && !ctrl[`AHP_CTRL_CONT]) errorCode <= `AHP_ERR_CONT;
      else if (clrCmd) errorCode <= 8'h0;
      contActive <= ctrl[`AHP_CTRL_CONT] && (contActive || contCmd);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speed ramp, one unit per cycle while the slope budget added each profile tick lasts
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      curSpeed <= 32'h0;
      rampBudget <= 40'h0;
    end else if (!runEn) begin
      curSpeed <= 32'h0;
      rampBudget <= 40'h0;
    end else if (curSpeed == tgtSpeed) begin
      rampBudget <= 40'h0;
    end else if (effTime == 32'h0) begin
      curSpeed <= tgtSpeed;
    end else if (profTick) begin
      rampBudget <= rampBudget + slope;
    end else if (rampBudget >= {8'h0, effTime}) begin
      curSpeed <= rampUp ? curSpeed + 32'h1 : curSpeed - 32'h1;
      rampBudget <= rampBudget - {8'h0, effTime};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Position, switch target and pin drive
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      position <= 32'h0;
      sspTarget <= 32'h0;
      pulseOut <= 1'b1;  // Idle level of the reset setting, no false step
      dirOut <= 1'b0;
    end else begin
      if (doneNow) position <= originAddr;
      else if (stepPulse) position <= runDir ? position - 32'h1 : position + 32'h1;
      if (sspCmd) begin
        sspTarget <= ctrl[`AHP_CTRL_SSPABS] ? sspDist : position + sspDist;
      end
      pulseOut <= ctrl[`AHP_CTRL_LEVEL] ? stepPulse : !stepPulse;
      dirOut <= runDir;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_limit_stop;
    limAhead && !emgHit && ((state == AHP_FAST && !originFast && !slowGo) ||
                            (state == AHP_SLOW && !homeOk));
  endsequence
  sequence s_still_wait;
    state == AHP_WAIT && !runEn;
  endsequence
  a_origin_halt: assert property (originHit |=> curSpeed == 32'h0 ##1 !stepPulse)
    else $error("pulses continue after home mark");
  a_emg_stop: assert property (emgHit |=> state == AHP_IDLE ##1 !stepPulse)
    else $error("pulses continue after emergency");
  a_origin_load: assert property (
    doneNow |=> position == $past(originAddr) && origin_state)
    else $error("origin not loaded at completion");
  a_limit_wait: assert property (s_limit_stop |=> s_still_wait)
    else $error("limit did not stop and wait");
  a_cont_refuse: assert property (
    contCmd && !ctrl[`AHP_CTRL_CONT] |=> errorCode == `AHP_ERR_CONT)
    else $error("continuous command not refused");
  a_flag_clear: assert property (
    startCmd && state == AHP_IDLE && !emgHit |=> !origin_state)
    else $error("origin flag kept on restart");
  a_start_dir: assert property (state == AHP_IDLE && next_state == AHP_FAST
    |=> runDir == $past(baseDir) ##1 dirOut == $past(baseDir, 2))
    else $error("wrong start direction");
  a_idle_level: assert property (
    state == AHP_IDLE [*3] |-> pulseOut == !$past(ctrl[`AHP_CTRL_LEVEL]))
    else $error("idle pulse level wrong");
  a_emg_origin: assert property (
    emgHit && ctrl[`AHP_CTRL_EMGORG] && !doneNow |=> !origin_state)
    else $error("origin kept after emergency");
endmodule

// ==== verif/ahp_drive_model.sv ====
/*
  Drive and home-mark model: counts step pulses, raises the home mark on request.
  Assumes pulseOut is one clock wide at its active level and markGo is bench driven.
*/
`timescale 1ns/1ps
module ahp_drive_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        pulseOut,    // Step pulse from the block
  input  wire logic        activeHigh,  // Pulse level setting
  input  wire logic        markGo,      // Bench asks for the home mark
  output logic             homeMark,    // Normally open home mark
  output logic [15:0]      stepCount    // Steps seen so far
);
  ////////////////////////////////////////////////////////////////////////////////
  // Mark is a clean rising edge, so normally-open polarity sees the origin
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      homeMark  <= 1'b0;
      stepCount <= 16'h0;
    end else begin
      homeMark <= markGo;
      if (pulseOut == activeHigh) begin
        stepCount <= stepCount + 16'h1;
      end
    end
  end
endmodule

// ==== verif/tb_axis_homing_and_param_logic.sv ====
/*
  Self-checking bench of the homing block over AXI4-Lite with a drive model.
  Assumes the high limit and the area sensor stay inactive; the low limit is hit once.
*/
`timescale 1ns/1ps
`include "ahp_defines.svh"
module tb_axis_homing_and_param_logic;
  logic        clk, reset, awvalid, wvalid, arvalid, markGo, emgIn;
  logic        awready, wready, bvalid, arready, rvalid, homeMark, pulseOut, dirOut;
  logic        origin_state, bready, rready, loLim, lvlHigh;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [15:0] stepCount, s0;
  int          err_total, total_checks;
  ahp_axis_homing #(.MS_CYCLES(20)) u_dut (.clk(clk), .reset(reset), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .hiLimitIn(1'b0), .loLimitIn(loLim), .areaSensorIn(1'b0),
    .homeMarkIn(homeMark), .emergency_halt(emgIn), .pulseOut(pulseOut),
    .dirOut(dirOut), .origin_state(origin_state));
  ahp_drive_model u_drv (.clk(clk), .reset(reset), .pulseOut(pulseOut), .activeHigh(lvlHigh),
    .markGo(markGo), .homeMark(homeMark), .stepCount(stepCount));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Write: address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1);
  endtask
  // Read and compare data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    chk(rdata, e);
    chk(32'(rresp), 32'(r));
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Watchdog: whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    wrap_up();
  end
  initial begin
    {reset, awvalid, wvalid, arvalid, markGo, emgIn, bready, rready, loLim, lvlHigh} = 10'h200;
    {awaddr, araddr, wdata} = '0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(pulseOut), 32'h1);
    rd(`AHP_OFF_OVR, 32'h2710, `AHP_RESP_OK);
    rd(8'h02, 32'h0, `AHP_RESP_ERR);
    wr(`AHP_OFF_CMD, 32'h2);
    rd(`AHP_OFF_STATUS, 32'ha000, `AHP_RESP_OK);
    wr(`AHP_OFF_CMD, 32'h8);
    wr(`AHP_OFF_CTRL, 32'h10);
    wr(`AHP_OFF_CMD, 32'h2);
    rd(`AHP_OFF_STATUS, 32'h0040, `AHP_RESP_OK);
    wr(`AHP_OFF_ORIGIN, 32'h8000_0005);
    wr(`AHP_OFF_COMP, 32'h3);
    // Speeds stay well under half the scaled clock rate
    wr(`AHP_OFF_HIGH, 32'h0000_0fa0);
    wr(`AHP_OFF_LOW, 32'h0000_07d0);
    wr(`AHP_OFF_DWELL, 32'h2);
    wr(`AHP_OFF_WAIT, 32'h2);
    wr(`AHP_OFF_CTRL, 32'he);
    wr(`AHP_OFF_CMD, 32'h1);
    rd(`AHP_OFF_STATUS, 32'h0001_0022, `AHP_RESP_OK);
    chk(32'(dirOut), 32'h1);
    // Low limit ahead in reverse travel: halt and wait, then restart
    loLim <= 1'b1;
    @(posedge clk);
    rd(`AHP_OFF_STATUS, 32'h0001_0025, `AHP_RESP_OK);
    loLim <= 1'b0;
    // Arm the mark just after a step so none is in flight at the halt
    do @(posedge clk); while (pulseOut !== 1'b0);
    @(posedge clk);
    s0 = stepCount;
    markGo <= 1'b1;
    repeat (2000) if (origin_state !== 1'b1) @(posedge clk);
    chk(32'(stepCount - s0), 32'h3);
    rd(`AHP_OFF_POS, 32'h8000_0005, `AHP_RESP_OK);
    rd(`AHP_OFF_STATUS, 32'h0001_0010, `AHP_RESP_OK);
    wr(`AHP_OFF_SSP, 32'h10);
    wr(`AHP_OFF_CMD, 32'h4);
    rd(`AHP_OFF_SSPTGT, 32'h8000_0015, `AHP_RESP_OK);
    wr(`AHP_OFF_CTRL, 32'h10e);
    wr(`AHP_OFF_CMD, 32'h4);
    rd(`AHP_OFF_SSPTGT, 32'h0000_0010, `AHP_RESP_OK);
    wr(`AHP_OFF_CTRL, 32'h2ae);
    lvlHigh <= 1'b1;
    emgIn <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(origin_state), 32'h0);
    chk(32'(pulseOut), 32'h0);
    wrap_up();
  end
endmodule
